// [rtl/bfs_pkg.sv]
package bfs_pkg;
  // datapath widths
  localparam int FIFO_W      = 64;    // bit fifo width
  localparam int HALF_W      = 32;    // upper half width
  localparam int DATA_W      = 32;    // fixed-point field width
  localparam int PTR_W       = 7;     // write pointer width
  localparam int LEN_W       = 6;     // length operand width taken
  localparam int MAX_LEN     = 32;    // largest legal field length
  localparam int MAX_PTR     = 64;    // largest legal pointer value
  localparam int LEVEL_MARK  = 32;    // level flag threshold
  localparam int MUL_W       = 64;    // multiplier product width
  localparam int FIFO_DEPTH  = 8;     // request fifo depth
  localparam logic [PTR_W-1:0] PTR_RST = 7'h00; // pointer reset value

  // operation codes on the request path
  typedef enum logic [3:0]
  {
    BFS_OP_DEP  = 4'h1,  // bit_deposit_op
    BFS_OP_EXT  = 4'h2,  // bit_extract_op
    BFS_OP_RDP  = 4'h3,  // read fifo_write_pointer
    BFS_OP_WRP  = 4'h4,  // write fifo_write_pointer
    BFS_OP_MF   = 4'h5,  // multiplier plus alu
    BFS_OP_DUAL = 4'h6   // dual add and subtract, optional multiply
  } bfs_op_e;

  // request word
  typedef struct packed
  {
    bfs_op_e           op;                 // operation
    logic              no_update_modifier; // extract peek only
    logic              use_imm;            // immediate replaces register
    logic              is_float;           // float form of dual / mf
    logic              sub_sel;            // mf alu subtracts
    logic              with_mul;           // dual also multiplies
    logic [11:0]       length_immediate;   // length immediate
    logic [PTR_W-1:0]  pointer_immediate;  // pointer immediate
    logic [DATA_W-1:0] src_x;              // first source operand
    logic [DATA_W-1:0] source_reg_y;       // second source / length reg
    logic [DATA_W-1:0] src_a;              // alu x input (third quartet)
    logic [DATA_W-1:0] src_b;              // alu y input (fourth quartet)
  } bfs_req_s;

  localparam int REQ_W = $bits(bfs_req_s); // request word width

  // result word
  typedef struct packed
  {
    logic [DATA_W-1:0] dest_reg;              // main result
    logic [DATA_W-1:0] sum_res;               // alu sum
    logic [DATA_W-1:0] diff_res;              // alu difference
    logic [MUL_W-1:0]  foreground_mac_result; // multiplier product
    logic              fifo_level_flag;       // level flag
    logic              shifter_overflow_flag; // overflow flag
    logic              shifter_zero_flag;     // zero flag
    logic              shifter_sign_flag;     // sign flag
  } bfs_res_s;

  // length taken from low six bits of register or immediate
  function automatic logic [LEN_W-1:0] bfs_len(input bfs_req_s r);
    bfs_len = r.use_imm ? r.length_immediate[LEN_W-1:0] : r.source_reg_y[LEN_W-1:0];
  endfunction : bfs_len

  // level flag test on a pointer value
  function automatic logic bfs_level(input logic [PTR_W-1:0] p);
    bfs_level = (p >= PTR_W'(LEVEL_MARK));
  endfunction : bfs_level
endpackage : bfs_pkg

// [rtl/bfs_if.sv]
`timescale 1ns/1ps
// decoder to shifter unit link: valid/ready request and answer
interface bfs_if
  import bfs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n
);
  logic     req_valid; // request offered
  logic     req_ready; // request accepted
  bfs_req_s req;       // request word
  logic     res_valid; // answer offered
  logic     res_ready; // answer accepted
  bfs_res_s res;       // answer word

  // decoder / register file end
  modport host
  (
    input  clk, reset_n, req_ready, res_valid, res,
    output req_valid, req, res_ready
  );
  // shifter unit end
  modport dev
  (
    input  clk, reset_n, req_valid, req, res_ready,
    output req_ready, res_valid, res
  );
endinterface : bfs_if

// [rtl/bfs_fifo.sv]
`timescale 1ns/1ps
// synchronous valid/ready fifo
module bfs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];  // storage
  logic [AW-1:0]    wr_ff;           // write index
  logic [AW-1:0]    rd_ff;           // read index
  logic [AW:0]      cnt_ff;          // fill count
  logic             push;            // write this cycle
  logic             pop;             // read this cycle

  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_ff[rd_ff];

  // storage write
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  // indices and count
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop)
      begin
        rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : bfs_fifo

// [rtl/bfs_unit.sv]
`timescale 1ns/1ps
// Behaviour
// - deposit ORs field below write pointer
// - deposit adds length to pointer
// - deposit length above 32 sets overflow
// - deposit overflowing space sets overflow; zero, sign cleared
// - deposit sets level when pointer reaches 32
// - pointer read returns pointer, clears three flags
// - pointer write keeps seven low bits
// - pointer above 64 sets overflow; level updated
// - extract returns top bits right justified
// - extract shifts fifo left, reduces pointer
// - peek extract leaves fifo, pointer, level
// - extract length above 32 sets overflow
// - extract underflow overflow; zero on zero result
// - multiply and alu run together, no background
// - operands come from fixed register quartets
// - dual add and subtract, fixed and float
// - short forms need source equal destination
module bfs_unit
  import bfs_pkg::*;
(
  // link to decoder
  bfs_if.dev lnk
);
  import bfs_pkg::*;

  logic [FIFO_W-1:0] bit_fifo_reg;          // bit fifo, msb aligned
  logic [PTR_W-1:0]  fifo_write_pointer;    // valid bit count
  logic              fifo_level_flag;       // level flag
  logic              res_valid_ff;          // answer held
  bfs_res_s          res_ff;                // answer word
  // the operation is decoded straight from the queue head
  logic              q_valid;               // queued request present
  bfs_req_s          q_req;                 // queued request
  logic              take;                  // request executes now

  // shared arithmetic of the operation decoder, kept in one place so
  // that the multifunction and dual forms cannot drift apart
  // unsigned product of the two multiplier operands
  function automatic logic [MUL_W-1:0] mul_prod(input bfs_req_s r);
    mul_prod = MUL_W'(r.src_x) * MUL_W'(r.source_reg_y);
  endfunction : mul_prod

  // alu sum of the third and fourth quartet operands
  function automatic logic [DATA_W-1:0] alu_sum(input bfs_req_s r);
    alu_sum = r.src_a + r.src_b;
  endfunction : alu_sum

  // alu difference of the third and fourth quartet operands
  function automatic logic [DATA_W-1:0] alu_diff(input bfs_req_s r);
    alu_diff = r.src_a - r.src_b;
  endfunction : alu_diff

  // field length above the legal maximum
  function automatic logic len_too_long(input logic [LEN_W-1:0] n);
    len_too_long = (n > LEN_W'(MAX_LEN));
  endfunction : len_too_long

  // request queue, drained while answer slot is free or its answer is being accepted
  bfs_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH)) u_q (
    .clk       (lnk.clk),
    .reset_n   (lnk.reset_n),
    .in_valid  (lnk.req_valid),
    .in_ready  (lnk.req_ready),
    .in_data   (lnk.req),
    .out_valid (q_valid),
    .out_ready (take),
    .out_data  (q_req)
  );

  // a new operation may run in the cycle its predecessor's answer leaves
  assign take      = q_valid && (!res_valid_ff || lnk.res_ready);
  assign lnk.res_valid = res_valid_ff;
  assign lnk.res       = res_ff;

  // next state of fifo, pointer, answer
  logic [FIFO_W-1:0] nxt_fifo;
  logic [PTR_W-1:0]  nxt_ptr;
  logic              nxt_level;
  bfs_res_s          nxt_res;
  logic [LEN_W-1:0]  len;
  logic [FIFO_W-1:0] field;
  logic [FIFO_W-1:0] mask;
  logic [HALF_W-1:0] top;
  logic [7:0]        room;

  // float add helper not modelled bitwise: float forms use same adders
  always_comb
  begin
    nxt_fifo  = bit_fifo_reg;
    nxt_ptr   = fifo_write_pointer;
    nxt_level = fifo_level_flag;
    nxt_res   = '0;
    len       = bfs_len(q_req);
    mask      = (len >= LEN_W'(MAX_LEN)) ? {{HALF_W{1'b1}}, {HALF_W{1'b0}}} >> HALF_W
                : ((FIFO_W'(1) << len) - FIFO_W'(1));
    field     = FIFO_W'(q_req.src_x) & mask;
    top       = bit_fifo_reg[FIFO_W-1 -: HALF_W];
    room      = 8'(MAX_PTR) - 8'(fifo_write_pointer);
    unique case (q_req.op)
      // deposit: or field in, advance pointer
      BFS_OP_DEP:
      begin
        // place field so its lsb sits len bits under pointer
        nxt_fifo = bit_fifo_reg | ((field << (FIFO_W - 32'(len))) >>
                   fifo_write_pointer);
        nxt_ptr  = fifo_write_pointer + PTR_W'(len);
        nxt_res.shifter_overflow_flag = len_too_long(len) || (8'(len) > room);
        nxt_level = bfs_level(nxt_ptr);
      end
      // extract: read top bits, shift unless peeking
      BFS_OP_EXT:
      begin
        // top len bits of upper half, zero filled
        nxt_res.dest_reg = (len == '0) ? '0 :
                           DATA_W'((FIFO_W'(top) >> (HALF_W - 32'(len))) & mask);
        nxt_res.shifter_overflow_flag = len_too_long(len) ||
                                        (PTR_W'(len) > fifo_write_pointer);
        nxt_res.shifter_zero_flag = (nxt_res.dest_reg == '0);
        if (!q_req.no_update_modifier)
        begin
          nxt_fifo  = bit_fifo_reg << len;
          nxt_ptr   = fifo_write_pointer - PTR_W'(len);
          nxt_level = bfs_level(nxt_ptr);
        end
        // peek keeps fifo, pointer, level
      end
      // pointer read: flags cleared, level kept
      BFS_OP_RDP:
      begin
        nxt_res.dest_reg = DATA_W'(fifo_write_pointer);
      end
      // pointer write: seven bits stored
      BFS_OP_WRP:
      begin
        nxt_ptr = q_req.use_imm ? q_req.pointer_immediate
                                : q_req.source_reg_y[PTR_W-1:0];
        // flags judge the stored seven-bit value
        nxt_res.shifter_overflow_flag = (nxt_ptr > PTR_W'(MAX_PTR));
        nxt_level = bfs_level(nxt_ptr);
      end
      // multifunction: product plus one alu result
      BFS_OP_MF:
      begin
        // multiplier on first quartets, alu on third and fourth
        nxt_res.foreground_mac_result = mul_prod(q_req);
        nxt_res.dest_reg = q_req.sub_sel ? alu_diff(q_req) : alu_sum(q_req);
      end
      // dual alu: sum and difference of one operand pair
      BFS_OP_DUAL:
      begin
        nxt_res.sum_res  = alu_sum(q_req);
        nxt_res.diff_res = alu_diff(q_req);
        // optional multiply beside the dual alu
        if (q_req.with_mul)
        begin
          nxt_res.foreground_mac_result = mul_prod(q_req);
        end
      end
      // unused codes answer with overflow, zero and sign flags cleared, level flag kept
      default:
      begin
        nxt_res = '0;
      end
    endcase
    // level flag reports the state left by this operation
    nxt_res.fifo_level_flag = nxt_level;
  end

  // fifo and pointer state
  always_ff @(posedge lnk.clk or negedge lnk.reset_n)
  begin
    if (!lnk.reset_n)
    begin
      // empty fifo, pointer at zero
      bit_fifo_reg       <= '0;
      fifo_write_pointer <= PTR_RST;
      fifo_level_flag    <= 1'b0;
    end
    else if (take)
    begin
      // only an executing operation moves the state
      bit_fifo_reg       <= nxt_fifo;
      fifo_write_pointer <= nxt_ptr;
      fifo_level_flag    <= nxt_level;
    end
  end

  // answer slot
  always_ff @(posedge lnk.clk or negedge lnk.reset_n)
  begin
    if (!lnk.reset_n)
    begin
      // no answer pending
      res_valid_ff <= 1'b0;
      res_ff       <= '0;
    end
    else if (take)
    begin
      // new answer replaces the one just accepted
      res_valid_ff <= 1'b1;
      res_ff       <= nxt_res;
    end
    else if (lnk.res_ready)
    begin
      // answer taken, slot empties
      res_valid_ff <= 1'b0;
    end
  end
endmodule : bfs_unit

// [rtl/bfs_host.sv]
`timescale 1ns/1ps
// decoder end: issues one request, waits for its answer
module bfs_host
  import bfs_pkg::*;
(
  // link to unit
  bfs_if.host       lnk,
  // user side
  input  wire logic     cmd_valid,
  output logic          cmd_ready,
  input  wire bfs_req_s cmd,
  output logic          ans_valid,
  output bfs_res_s      ans
);
  import bfs_pkg::*;

  logic     busy_ff;      // request outstanding
  logic     req_valid_ff; // request on link
  bfs_req_s req_ff;       // request word
  logic     ans_valid_ff; // answer pulse
  bfs_res_s ans_ff;       // answer word
  logic     legal;        // request obeys caller limits

  // caller limits on lengths and on immediate pointer values
  assign legal = !(((cmd.op == BFS_OP_DEP) || (cmd.op == BFS_OP_EXT)) &&
                   (bfs_len(cmd) > LEN_W'(MAX_LEN))) &&
                 !((cmd.op == BFS_OP_WRP) && cmd.use_imm &&
                   (cmd.pointer_immediate > PTR_W'(MAX_PTR)));

  assign cmd_ready     = !busy_ff;
  assign lnk.req_valid = req_valid_ff;
  assign lnk.req       = req_ff;
  assign lnk.res_ready = 1'b1;
  assign ans_valid     = ans_valid_ff;
  assign ans           = ans_ff;

  // issue and completion; illegal requests are dropped
  always_ff @(posedge lnk.clk or negedge lnk.reset_n)
  begin
    if (!lnk.reset_n)
    begin
      busy_ff      <= 1'b0;
      req_valid_ff <= 1'b0;
      req_ff       <= '0;
      ans_valid_ff <= 1'b0;
      ans_ff       <= '0;
    end
    else
    begin
      ans_valid_ff <= 1'b0;
      if (!busy_ff && cmd_valid && legal)
      begin
        busy_ff      <= 1'b1;
        req_valid_ff <= 1'b1;
        req_ff       <= cmd;
      end
      if (req_valid_ff && lnk.req_ready)
      begin
        req_valid_ff <= 1'b0;
      end
      if (busy_ff && lnk.res_valid)
      begin
        busy_ff      <= 1'b0;
        ans_valid_ff <= 1'b1;
        ans_ff       <= lnk.res;
      end
    end
  end
endmodule : bfs_host

// [testbench/bfs_link_properties.sv]
`timescale 1ns/1ps
// watches the decoder to shifter link
module bfs_link_checker
  import bfs_pkg::*;
(
  // clock and reset
  input wire logic     clk,
  input wire logic     reset_n,
  // request side
  input wire logic     req_valid,
  input wire logic     req_ready,
  input wire bfs_req_s req,
  // answer side
  input wire logic     res_valid,
  input wire logic     res_ready,
  input wire bfs_res_s res
);
  import bfs_pkg::*;
  bfs_req_s   last_ff; // request being answered
  logic [5:0] len;     // its length
  logic [6:0] pval;    // its pointer value
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // remember the accepted request, one outstanding at a time
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      last_ff <= '0;
    else if (req_valid && req_ready)
      last_ff <= req;
  end
  assign len  = last_ff.use_imm ? last_ff.length_immediate[5:0] : last_ff.source_reg_y[5:0];
  assign pval = last_ff.use_imm ? last_ff.pointer_immediate : last_ff.source_reg_y[6:0];
  req_once_a: assert property (req_valid && req_ready |=> !req_valid)
    else $error("second request while one outstanding");
  sign_clear_a: assert property (res_valid |-> !res.shifter_sign_flag)
    else $error("sign flag set");
  rdp_flags_a: assert property (res_valid && last_ff.op == BFS_OP_RDP |->
    !res.shifter_overflow_flag && !res.shifter_zero_flag
    && res.fifo_level_flag == (res.dest_reg >= 32)) else $error("pointer read flags wrong");
  wrp_flags_a: assert property (res_valid && last_ff.op == BFS_OP_WRP |->
    res.shifter_overflow_flag == (pval > 64) && res.fifo_level_flag == (pval >= 32)
    && !res.shifter_zero_flag) else $error("pointer write flags wrong");
  dep_flags_a: assert property (res_valid && last_ff.op == BFS_OP_DEP |->
    !res.shifter_zero_flag && (len <= 32 || res.shifter_overflow_flag))
    else $error("deposit flags wrong");
  ext_zero_a: assert property (res_valid && last_ff.op == BFS_OP_EXT |->
    res.shifter_zero_flag == (res.dest_reg == 0)) else $error("extract zero flag wrong");
  ext_fill_a: assert property (res_valid && last_ff.op == BFS_OP_EXT
    && !res.shifter_overflow_flag |-> (res.dest_reg >> len) == 0)
    else $error("extract not zero filled");
  dual_alu_a: assert property (res_valid && last_ff.op == BFS_OP_DUAL |->
    res.sum_res == last_ff.src_a + last_ff.src_b
    && res.diff_res == last_ff.src_a - last_ff.src_b) else $error("dual sum or difference wrong");
  mf_mul_a: assert property (res_valid && last_ff.op == BFS_OP_MF |->
    res.foreground_mac_result == 64'(last_ff.src_x) * 64'(last_ff.source_reg_y))
    else $error("multifunction product wrong");
endmodule : bfs_link_checker

// [testbench/test_bit_fifo_shifter_unit.sv]
`timescale 1ns/1ps
// host user side driven, answers compared with a bit fifo model
module test_bit_fifo_shifter_unit;
  import bfs_pkg::*;
  logic        clk = 1'b0;      // core clock
  logic        reset_n = 1'b0;  // async reset
  logic        cmd_valid = 1'b0; // command offered
  bfs_req_s    cmd = '0;        // command word
  logic        cmd_ready;       // host idle
  logic        ans_valid;       // answer pulse
  bfs_res_s    ans;             // answer word
  int          num_errors = 0;  // mismatches
  int          samples_checked = 0; // comparisons
  int          cycles = 0;      // run length
  logic [63:0] fifo_m;          // model fifo
  logic [6:0]  ptr_m;           // model pointer
  logic        lvl_m;           // model level flag
  int          lim;             // legal length bound
  bfs_if lnk (.clk(clk), .reset_n(reset_n));
  bfs_unit i_bfs_unit (.lnk(lnk));
  bfs_host i_bfs_host (.lnk(lnk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .ans_valid(ans_valid), .ans(ans));
  bfs_link_checker i_bfs_link_checker (.clk(clk), .reset_n(reset_n), .req_valid(lnk.req_valid),
    .req_ready(lnk.req_ready), .req(lnk.req), .res_valid(lnk.res_valid),
    .res_ready(lnk.res_ready), .res(lnk.res));
  // 100 ns clock
  always #50 clk = ~clk;
  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      final_report();
    end
  end
  // compare one value
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // verdict and end of run
  task automatic final_report;
    $display("errors %0d checked %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // send one operation, wait for its answer, compare with the model
  task automatic run(input bfs_op_e op, input logic nu, input int n);
    bfs_req_s    r;
    logic [63:0] d;
    logic        ov;
    logic [63:0] pe;
    r = '0;
    r.op = op;
    r.no_update_modifier = nu;
    r.use_imm = (n > 64) ? 1'b0 : 1'($urandom);
    r.length_immediate = {6'($urandom), 6'(n)};
    r.pointer_immediate = 7'(n);
    r.source_reg_y = (op == BFS_OP_WRP) ? {25'($urandom), 7'(n)} : {26'($urandom), 6'(n)};
    r.src_x = $urandom;
    r.src_a = (op == BFS_OP_MF) ? ans.dest_reg : $urandom;
    r.src_b = $urandom;
    r.with_mul = 1'($urandom);
    r.sub_sel = 1'($urandom);
    r.is_float = 1'($urandom);
    d = 64'h0;
    ov = 1'b0;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    cmd <= r;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    do @(posedge clk); while (ans_valid !== 1'b1);
    case (op)
      BFS_OP_DEP:
      begin
        ov = (n > 32) || (n > 64 - ptr_m);
        fifo_m |= (64'(r.src_x) & ((64'h1 << n) - 64'h1)) << (64 - ptr_m - n);
        ptr_m += 7'(n);
        lvl_m = (ptr_m >= 32);
      end
      BFS_OP_EXT:
      begin
        ov = (n > 32) || (n > ptr_m);
        d = (n == 0) ? 64'h0 : fifo_m >> (64 - n);
        if (!ov)
          check("extract data", 64'(ans.dest_reg), d);
        if (!nu)
        begin
          fifo_m <<= n;
          ptr_m -= 7'(n);
          lvl_m = (ptr_m >= 32);
        end
      end
      BFS_OP_RDP:
        check("pointer read", 64'(ans.dest_reg), 64'(ptr_m));
      BFS_OP_WRP:
      begin
        ptr_m = 7'(n);
        ov = (ptr_m > 64);
        lvl_m = (ptr_m >= 32);
      end
      default:
      begin
        pe = (op == BFS_OP_DUAL && !r.with_mul) ? 64'h0 : 64'(r.src_x) * 64'(r.source_reg_y);
        check("product", ans.foreground_mac_result, pe);
        if (op == BFS_OP_MF)
        begin
          d = {32'h0, r.sub_sel ? r.src_a - r.src_b : r.src_a + r.src_b};
          check("alu result", 64'(ans.dest_reg), d);
        end
        if (op == BFS_OP_DUAL)
          check("sum diff", {ans.sum_res, ans.diff_res},
            {r.src_a + r.src_b, r.src_a - r.src_b});
        return;
      end
    endcase
    check("overflow", ans.shifter_overflow_flag, ov);
    check("sign", ans.shifter_sign_flag, 1'b0);
    if (!ov || op == BFS_OP_WRP)
    begin
      check("zero", ans.shifter_zero_flag, op == BFS_OP_EXT && d == 0);
      check("level", ans.fifo_level_flag, lvl_m);
    end
  endtask : run
  // main sequence
  initial
  begin
    void'($urandom(41));
    fifo_m = 64'h0;
    ptr_m = 7'h00;
    lvl_m = 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    run(BFS_OP_RDP, 1'b0, 0);
    run(BFS_OP_WRP, 1'b0, 64);
    run(BFS_OP_WRP, 1'b0, 0);
    run(BFS_OP_DEP, 1'b0, 32);
    run(BFS_OP_DEP, 1'b0, 32);
    run(BFS_OP_EXT, 1'b1, 32);
    run(BFS_OP_EXT, 1'b0, 32);
    run(BFS_OP_EXT, 1'b0, 0);
    run(BFS_OP_RDP, 1'b0, 0);
    repeat (2)
    begin
      run(BFS_OP_MF, 1'b0, 0);
      run(BFS_OP_DUAL, 1'b0, 0);
    end
    repeat (80)
    begin
      lim = (64 - ptr_m > 32) ? 32 : 64 - ptr_m;
      case ($urandom_range(0, 4))
        0: run(BFS_OP_DEP, 1'b0, $urandom_range(0, lim));
        1: run(BFS_OP_EXT, 1'b0, $urandom_range(0, (ptr_m > 32) ? 32 : ptr_m));
        2: run(BFS_OP_EXT, 1'b1, $urandom_range(0, (ptr_m > 32) ? 32 : ptr_m));
        3: run(BFS_OP_RDP, 1'b0, 0);
        default: run(BFS_OP_WRP, 1'b0, $urandom_range(0, 64));
      endcase
    end
    // mid-run reset: pointer, fifo and level return to zero
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    fifo_m = 64'h0;
    ptr_m = 7'h00;
    lvl_m = 1'b0;
    run(BFS_OP_RDP, 1'b0, 0);
    run(BFS_OP_EXT, 1'b0, 0);
    run(BFS_OP_WRP, 1'b0, 65);
    run(BFS_OP_WRP, 1'b0, 5);
    run(BFS_OP_WRP, 1'b0, 60);
    run(BFS_OP_DEP, 1'b0, 10);
    run(BFS_OP_WRP, 1'b0, 0);
    run(BFS_OP_EXT, 1'b0, 5);
    final_report();
  end
endmodule : test_bit_fifo_shifter_unit
